/* File: hdl/tdc_defs.vh */
`ifndef TDC_DEFS_VH
`define TDC_DEFS_VH

// Command addresses
`define TDC_CMD_RESET   8'h01
`define TDC_CMD_CTRL    8'h30
`define TDC_CMD_AUX     8'h32
`define TDC_CMD_GEN     8'h33
`define TDC_CMD_TONE    8'h34
`define TDC_CMD_STATUS  8'h40
`define TDC_CMD_PARAM   8'h41

// Register reset value
`define TDC_REG_RST     8'h00

// decoder_control fields
`define TDC_CTRL_RAMSEL 7
`define TDC_CTRL_FAST   6
`define TDC_CTRL_BW_HI  5
`define TDC_CTRL_BW_LO  2
`define TDC_CTRL_OPM_HI 1
`define TDC_CTRL_OPM_LO 0

// Operation modes
`define TDC_OPM_ZERO    2'h0
`define TDC_OPM_CLEAR   2'h1
`define TDC_OPM_NORMAL  2'h2

// input_path_control: only bit 0 is writable
`define TDC_AUX_MASK    8'h01
`define TDC_AUX_HOLD    0

// decode_group_select fields
`define TDC_GEN_MASK    8'hC0
`define TDC_GEN_DM_HI   7
`define TDC_GEN_DM_LO   6
`define TDC_DM_OFF      2'h0
`define TDC_DM_SECOND   2'h1
`define TDC_DM_FIRST    2'h2

// Tone entry fields
`define TDC_ENT_G1      15
`define TDC_ENT_G2      14
`define TDC_ENT_N_HI    13
`define TDC_ENT_N_LO    7
`define TDC_ENT_R_HI    6
`define TDC_ENT_R_LO    0

// Serial byte framing
`define TDC_BIT_LAST    3'h7

`endif

/* File: hdl/tdc_sync.v */
`timescale 1ns/1ps
// Two-flop synchroniser for pin inputs
module tdc_sync #(
  parameter WIDTH = 1,
  parameter [WIDTH-1:0] INIT = {WIDTH{1'b0}}
) (
  input  wire             clk,
  input  wire             rst_n,
  input  wire             clk_en,
  input  wire [WIDTH-1:0] d,
  output wire [WIDTH-1:0] q
);
  reg [WIDTH-1:0] meta_ff;
  reg [WIDTH-1:0] sync_ff;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_ff <= INIT;
      sync_ff <= INIT;
    end else if (clk_en) begin
      meta_ff <= d;
      sync_ff <= meta_ff;
    end
  end

  assign q = sync_ff;
endmodule // tdc_sync

/* File: hdl/tdc_top.v */
`timescale 1ns/1ps
// Function
// - Tone onset raises interrupt and reports matched list entry.
// - Tone end raises another interrupt and reports no-tone.
// - Any of up to 32 listed tones decoded, one at a time.
// - Two 32-entry lists keep contents across selection and zero-power.
// - Scan selected-group entries; first match reports and stops search until tone ends.
// - Each decode state change sets a status flag while a group search is selected.
// - Control bit 7 picks the active list for loading and decoding.
// - General bits 7:6 choose first or second group search.
// - Control bit 6 selects slow (0) or fast (1) measurement.
// - Each transaction opens with an address/command byte.
// - Reset command clears writable registers, entering zero-power.
// - Reset command clears list-full flag, keeps list contents.
// - Control registers are 8-bit and write-only.
// - Mode 00 zero-power, 01 clear list, 10 decode, 11 reserved.
// - Decode mode 00 off, 01 second group, 10 first group.
// - Interrupt pin is active-low open-drain.
// - Serial bytes are 8 bits, MSB first, host clocked.
`include "tdc_defs.vh"

module tdc_top #(
  parameter AW = 5
) (
  input  wire       clk,
  input  wire       reset_n,
  input  wire       clk_en,
  input  wire       serial_clock,
  input  wire       command_data,
  input  wire       transfer_select_low,
  output wire       reply_data_o,
  output wire       reply_data_oe,
  output wire       interrupt_out_low_o,
  output wire       interrupt_out_low_oe,
  input  wire       tone_present,
  input  wire [6:0] tone_n,
  input  wire [6:0] tone_r,
  output wire       fast_mode,
  output wire [3:0] decode_bandwidth,
  output wire       input_flow_hold,
  output wire       zero_power
);
  localparam DEPTH    = 1 << AW;
  localparam S_ADDR   = 2'h0;
  localparam S_DATA   = 2'h1;
  localparam S_REPLY  = 2'h2;
  localparam S_SKIP   = 2'h3;

  reg         rst_meta_ff;
  reg         rst_n_ff;
  wire        sclk_s;
  wire        cdat_s;
  wire        csn_s;
  reg         sclk_d_ff;
  reg  [1:0]  st_ff;
  reg  [2:0]  bit_cnt_ff;
  reg  [7:0]  sh_ff;
  reg  [7:0]  cmd_ff;
  reg  [7:0]  hi_ff;
  reg         hi_done_ff;
  reg  [7:0]  rsh_ff;
  reg         rply_ff;
  reg  [7:0]  ctrl_ff;
  reg  [7:0]  aux_ff;
  reg  [7:0]  gen_ff;
  reg         soft_rst_ff;
  reg         stat_rd_ff;
  reg         wr_ff;
  reg  [15:0] wr_data_ff;
  reg  [15:0] mem [0:2*DEPTH-1];
  reg  [2*DEPTH-1:0] valid_ff;
  reg  [2*AW-1:0] wp_ff;
  reg         full_ff;
  reg  [AW-1:0] scan_ff;
  reg         det_ff;
  reg  [AW-1:0] det_idx_ff;
  reg  [1:0]  det_grp_ff;
  reg         chg_ff;
  reg         irq_ff;

  wire        rise = sclk_s & ~sclk_d_ff;
  wire [7:0]  byte_in = {sh_ff[6:0], cdat_s};
  wire        sel = ctrl_ff[`TDC_CTRL_RAMSEL];
  wire [1:0]  opm = ctrl_ff[`TDC_CTRL_OPM_HI:`TDC_CTRL_OPM_LO];
  wire [1:0]  dm = gen_ff[`TDC_GEN_DM_HI:`TDC_GEN_DM_LO];
  wire        dm_on = (dm == `TDC_DM_FIRST) || (dm == `TDC_DM_SECOND);
  wire [AW:0] scan_addr = {sel, scan_ff};
  wire [15:0] ent = mem[scan_addr];
  wire [AW-1:0] wp_sel = sel ? wp_ff[2*AW-1:AW] : wp_ff[AW-1:0];
  wire [7:0]  status_byte = {5'h00, full_ff, det_ff, chg_ff};
  wire [7:0]  param_byte = {det_ff, det_grp_ff, det_idx_ff};

  // Entry with zero N and R marks an unused location
  wire ent_used = valid_ff[scan_addr] &&
                  (ent[`TDC_ENT_N_HI:`TDC_ENT_R_LO] != 14'h0000);
  wire grp_ok = (dm == `TDC_DM_FIRST) ? ent[`TDC_ENT_G1] :
                (dm == `TDC_DM_SECOND) ? ent[`TDC_ENT_G2] : 1'b0;
  wire hit = ent_used && grp_ok &&
             (ent[`TDC_ENT_N_HI:`TDC_ENT_N_LO] == tone_n) &&
             (ent[`TDC_ENT_R_HI:`TDC_ENT_R_LO] == tone_r);
  wire decoding = (opm == `TDC_OPM_NORMAL) && dm_on &&
                  !aux_ff[`TDC_AUX_HOLD];

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta_ff <= 1'b0;
      rst_n_ff    <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_n_ff    <= rst_meta_ff;
    end
  end

  tdc_sync #(
    .WIDTH (3),
    .INIT  (3'h1)
  ) u_sync (
    .clk    (clk),
    .rst_n  (rst_n_ff),
    .clk_en (clk_en),
    .d      ({serial_clock, command_data, transfer_select_low}),
    .q      ({sclk_s, cdat_s, csn_s})
  );

  // Serial slave and write-only registers
  always @(posedge clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      sclk_d_ff   <= 1'b0;
      st_ff       <= S_ADDR;
      bit_cnt_ff  <= 3'h0;
      sh_ff       <= 8'h00;
      cmd_ff      <= 8'h00;
      hi_ff       <= 8'h00;
      hi_done_ff  <= 1'b0;
      rsh_ff      <= 8'h00;
      rply_ff     <= 1'b0;
      ctrl_ff     <= `TDC_REG_RST;
      aux_ff      <= `TDC_REG_RST;
      gen_ff      <= `TDC_REG_RST;
      soft_rst_ff <= 1'b0;
      stat_rd_ff  <= 1'b0;
      wr_ff       <= 1'b0;
      wr_data_ff  <= 16'h0000;
    end else if (clk_en) begin
      sclk_d_ff   <= sclk_s;
      soft_rst_ff <= 1'b0;
      stat_rd_ff  <= 1'b0;
      wr_ff       <= 1'b0;
      if (csn_s) begin
        st_ff      <= S_ADDR;
        bit_cnt_ff <= 3'h0;
        hi_done_ff <= 1'b0;
        rply_ff    <= 1'b0;
      end else if (rise) begin
        sh_ff      <= byte_in;
        bit_cnt_ff <= bit_cnt_ff + 3'h1;
        if (st_ff == S_REPLY)
          rsh_ff <= {rsh_ff[6:0], 1'b0};
        if (bit_cnt_ff == `TDC_BIT_LAST) begin
          case (st_ff)
            S_ADDR: begin
              cmd_ff <= byte_in;
              case (byte_in)
                `TDC_CMD_RESET: begin
                  ctrl_ff     <= `TDC_REG_RST;
                  aux_ff      <= `TDC_REG_RST;
                  gen_ff      <= `TDC_REG_RST;
                  soft_rst_ff <= 1'b1;
                  st_ff       <= S_SKIP;
                end
                `TDC_CMD_CTRL, `TDC_CMD_AUX, `TDC_CMD_GEN,
                `TDC_CMD_TONE: begin
                  st_ff <= S_DATA;
                end
                `TDC_CMD_STATUS: begin
                  rsh_ff     <= status_byte;
                  stat_rd_ff <= 1'b1;
                  rply_ff    <= 1'b1;
                  st_ff      <= S_REPLY;
                end
                `TDC_CMD_PARAM: begin
                  rsh_ff  <= param_byte;
                  rply_ff <= 1'b1;
                  st_ff   <= S_REPLY;
                end
                default: st_ff <= S_SKIP;
              endcase
            end
            S_DATA: begin
              case (cmd_ff)
                `TDC_CMD_CTRL: begin
                  ctrl_ff <= byte_in;
                  st_ff   <= S_SKIP;
                end
                `TDC_CMD_AUX: begin
                  aux_ff <= byte_in & `TDC_AUX_MASK;
                  st_ff  <= S_SKIP;
                end
                `TDC_CMD_GEN: begin
                  gen_ff <= byte_in & `TDC_GEN_MASK;
                  st_ff  <= S_SKIP;
                end
                `TDC_CMD_TONE: begin
                  if (!hi_done_ff) begin
                    hi_ff      <= byte_in;
                    hi_done_ff <= 1'b1;
                  end else begin
                    wr_data_ff <= {hi_ff, byte_in};
                    wr_ff      <= 1'b1;
                    st_ff      <= S_SKIP;
                  end
                end
                default: st_ff <= S_SKIP;
              endcase
            end
            default: st_ff <= st_ff;
          endcase
        end
      end
    end
  end

  // Tone lists: contents survive reset and mode changes, only flags and write pointers clear
  always @(posedge clk) begin
    if (clk_en && wr_ff && opm != `TDC_OPM_CLEAR)
      mem[{sel, wp_sel}] <= wr_data_ff;
  end

  always @(posedge clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      valid_ff <= {2*DEPTH{1'b0}};
      wp_ff    <= {2*AW{1'b0}};
      full_ff  <= 1'b0;
    end else if (clk_en) begin
      if (opm == `TDC_OPM_CLEAR) begin
        valid_ff[sel*DEPTH +: DEPTH] <= {DEPTH{1'b0}};
        wp_ff[sel*AW +: AW]          <= {AW{1'b0}};
        full_ff                      <= 1'b0;
      end else begin
        if (wr_ff) begin
          valid_ff[{sel, wp_sel}] <= 1'b1;
          wp_ff[sel*AW +: AW]     <= wp_sel + {{(AW-1){1'b0}}, 1'b1};
          if (wp_sel == {AW{1'b1}})
            full_ff <= 1'b1;
        end
        if (soft_rst_ff)
          full_ff <= 1'b0;
      end
    end
  end

  // Decode search and state-change flag
  always @(posedge clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      scan_ff    <= {AW{1'b0}};
      det_ff     <= 1'b0;
      det_idx_ff <= {AW{1'b0}};
      det_grp_ff <= 2'h0;
      chg_ff     <= 1'b0;
      irq_ff     <= 1'b0;
    end else if (clk_en) begin
      if (!decoding || !tone_present) begin
        scan_ff <= {AW{1'b0}};
        det_ff  <= 1'b0;
        if (det_ff && dm_on)
          chg_ff <= 1'b1;
        else if (stat_rd_ff)
          chg_ff <= 1'b0;
      end else if (!det_ff && hit) begin
        det_ff     <= 1'b1;
        det_idx_ff <= scan_ff;
        det_grp_ff <= ent[`TDC_ENT_G1:`TDC_ENT_G2];
        scan_ff    <= {AW{1'b0}};
        chg_ff     <= 1'b1;
      end else begin
        if (!det_ff)
          scan_ff <= scan_ff + {{(AW-1){1'b0}}, 1'b1};
        if (stat_rd_ff)
          chg_ff <= 1'b0;
      end
      irq_ff <= chg_ff & dm_on;
    end
  end

  assign reply_data_o         = rsh_ff[7];
  assign reply_data_oe        = rply_ff & ~csn_s;
  assign interrupt_out_low_o  = 1'b0;
  assign interrupt_out_low_oe = irq_ff;
  assign fast_mode            = ctrl_ff[`TDC_CTRL_FAST];
  assign decode_bandwidth     = ctrl_ff[`TDC_CTRL_BW_HI:`TDC_CTRL_BW_LO];
  assign input_flow_hold      = aux_ff[`TDC_AUX_HOLD];
  assign zero_power           = (opm == `TDC_OPM_ZERO);
endmodule // tdc_top

/* File: tb/tdc_top_props.sv */
`timescale 1ns/1ps
module tdc_props (
  input wire       clk,
  input wire       reset_n,
  input wire       transfer_select_low,
  input wire       reply_data_oe,
  input wire       interrupt_out_low_o,
  input wire       interrupt_out_low_oe,
  input wire       tone_present,
  input wire       fast_mode,
  input wire [3:0] decode_bandwidth,
  input wire       input_flow_hold,
  input wire       zero_power
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  reset_val_a:
    assert property ($rose(reset_n) |-> zero_power && !fast_mode &&
      decode_bandwidth == 4'h0 && !interrupt_out_low_oe)
    else $error("bad reset value");
  irq_drive_a:
    assert property (interrupt_out_low_oe |-> !interrupt_out_low_o)
    else $error("irq pin not pulled low");
  reply_idle_a:
    assert property (transfer_select_low [*4] |-> !reply_data_oe)
    else $error("reply driven outside frame");
  reply_start_a:
    assert property ($rose(reply_data_oe) |-> !$past(transfer_select_low, 100))
    else $error("reply before address byte");
  ctrl_quiet_a:
    assert property (transfer_select_low [*8] |-> $stable({fast_mode,
      decode_bandwidth, input_flow_hold, zero_power}))
    else $error("register changed outside frame");
  zp_silent_a:
    assert property (zero_power [*3] |-> !$rose(interrupt_out_low_oe))
    else $error("irq in zero power");
  hold_silent_a:
    assert property (input_flow_hold [*3] |-> !$rose(interrupt_out_low_oe))
    else $error("irq while input held");
  irq_cause_a:
    assert property ($rose(interrupt_out_low_oe) |->
      $past(tone_present, 2) || $past(tone_present, 3))
    else $error("irq without tone change");
endmodule // tdc_props

bind tdc_top tdc_props tdc_props_inst (
  .clk, .reset_n, .transfer_select_low, .reply_data_oe,
  .interrupt_out_low_o, .interrupt_out_low_oe, .tone_present,
  .fast_mode, .decode_bandwidth, .input_flow_hold, .zero_power
);

/* File: tb/tdc_host.sv */
`timescale 1ns/1ps
module tdc_host (
  output logic sclk,
  output logic sdat,
  output logic sel_n,
  input  wire  rdata
);
  initial begin
    sclk = 1'b0;
    sdat = 1'b0;
    sel_n = 1'b1;
  end
  // Serial clock only runs inside frames
  task automatic xfer(input logic [7:0] b, output logic [7:0] r);
    for (int i = 7; i >= 0; i--) begin
      sdat <= b[i];
      #32 sclk <= 1'b1;
      r[i] = rdata;
      #32 sclk <= 1'b0;
    end
  endtask
  task automatic frame(input logic [7:0] a, input int n,
                       input logic [15:0] d, output logic [7:0] r);
    sel_n <= 1'b0;
    #64 xfer(a, r);
    for (int k = n - 1; k >= 0; k--) xfer(d[8*k +: 8], r);
    #64 sel_n <= 1'b1;
    // Idle data line shows the inverse of the last bit
    sdat <= ~sdat;
    #200;
  endtask
endmodule // tdc_host

/* File: tb/tdc_top_tb.sv */
`timescale 1ns/1ps
module tdc_top_tb;
  logic       clk;
  logic       reset_n;
  logic       ce;
  logic       tone_present;
  logic [6:0] tone_n;
  logic [6:0] tone_r;
  logic [7:0] rd;
  logic [7:0] c;
  logic [6:0] n1;
  logic [6:0] r1;
  int         n_fail;
  int         samples_checked;
  wire        sclk, sdat, sel_n, rdo, roe, irq_o, irq_oe, fast, hold, zp;
  wire  [3:0] bw;
  wire        reply_w = roe ? rdo : 1'bz;
  wire  [7:0] ctl_seen = {2'h0, zp, fast, bw};

  tdc_top tdc_top_inst (
    .clk, .reset_n, .clk_en(ce), .serial_clock(sclk),
    .command_data(sdat), .transfer_select_low(sel_n),
    .reply_data_o(rdo), .reply_data_oe(roe),
    .interrupt_out_low_o(irq_o), .interrupt_out_low_oe(irq_oe),
    .tone_present, .tone_n, .tone_r, .fast_mode(fast),
    .decode_bandwidth(bw), .input_flow_hold(hold), .zero_power(zp)
  );
  tdc_host tdc_host_inst (.sclk, .sdat, .sel_n, .rdata(reply_w));

  function automatic logic [7:0] ctl(input logic [7:0] v);
    return {2'h0, v[1:0] == 2'h0, v[6], v[5:2]};
  endfunction
  function automatic logic [7:0] rep(input logic [1:0] g,
                                     input logic [4:0] k);
    return {1'b1, g, k};
  endfunction
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic results;
    if (n_fail == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    tdc_host_inst.frame(a, 1, {8'h00, d}, rd);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    tdc_host_inst.frame(a, 1, 16'h00FF, rd);
    check(rd, e);
  endtask
  task automatic ev(input logic on, input logic [6:0] n, r, input logic e);
    check({7'h00, irq_oe}, 8'h00);
    @(posedge clk);
    tone_n <= n;
    tone_r <= r;
    tone_present <= on;
    for (int i = 0; i < 40 && irq_oe !== 1'b1; i++) @(negedge clk);
    check({7'h00, irq_oe}, {7'h00, e});
  endtask
  task automatic hit(input logic [6:0] n, r, input logic [7:0] e);
    ev(1'b1, n, r, 1'b1);
    rdc(8'h41, e);
    rdc(8'h40, 8'h03);
    ev(1'b0, n, r, 1'b1);
    rdc(8'h40, 8'h01);
    rdc(8'h40, 8'h00);
  endtask

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial begin
    #400000;
    n_fail++;
    results;
  end
  initial begin
    n_fail = 0;
    samples_checked = 0;
    reset_n = 1'b0;
    ce = 1'b1;
    tone_present = 1'b0;
    tone_n = 7'h00;
    tone_r = 7'h00;
    c = 8'($urandom(66152));
    n1 = {1'b1, 6'($urandom)};
    r1 = 7'($urandom);
    repeat (16) @(posedge clk);
    reset_n <= 1'b1;
    repeat (8) @(posedge clk);
    check(ctl_seen, ctl(8'h00));
    for (int i = 0; i < 6; i++) begin
      c = (i == 0) ? 8'hFF : 8'($urandom);
      wr(8'h30, c);
      check(ctl_seen, ctl(c));
    end
    wr(8'h55, 8'h00);
    check(ctl_seen, ctl(c));
    wr(8'h32, 8'hFF);
    check({7'h00, hold}, 8'h01);
    wr(8'h32, 8'hFE);
    check({7'h00, hold}, 8'h00);
    wr(8'h33, 8'h00);
    wr(8'h30, 8'h01);
    wr(8'h32, 8'h01);
    wr(8'h30, 8'h02);
    tdc_host_inst.frame(8'h34, 2, {2'h2, n1, r1}, rd);
    tdc_host_inst.frame(8'h34, 2, {2'h1, n1 ^ 7'h01, r1}, rd);
    wr(8'h32, 8'h00);
    wr(8'h33, 8'h40);
    ev(1'b1, n1, r1, 1'b0);
    @(posedge clk) tone_present <= 1'b0;
    hit(n1 ^ 7'h01, r1, rep(2'h1, 5'h01));
    wr(8'h33, 8'h80);
    hit(n1, r1, rep(2'h2, 5'h00));
    wr(8'h33, 8'h00);
    ev(1'b1, n1, r1, 1'b0);
    @(posedge clk) tone_present <= 1'b0;
    wr(8'h33, 8'hC0);
    ev(1'b1, n1, r1, 1'b0);
    @(posedge clk) tone_present <= 1'b0;
    wr(8'h30, 8'h81);
    wr(8'h32, 8'h01);
    wr(8'h30, 8'h82);
    for (int i = 0; i < 32; i++)
      tdc_host_inst.frame(8'h34, 2, {2'h3, 7'(i + 1), 7'h00}, rd);
    wr(8'h32, 8'h00);
    rdc(8'h40, 8'h04);
    wr(8'h33, 8'h80);
    ev(1'b1, n1, r1, 1'b0);
    @(posedge clk) tone_present <= 1'b0;
    tdc_host_inst.frame(8'h01, 0, 16'h0000, rd);
    check(ctl_seen, ctl(8'h00));
    rdc(8'h40, 8'h00);
    wr(8'h30, 8'h02);
    wr(8'h33, 8'h80);
    // A tone seen only while the clock enable is low must not decode
    @(posedge clk) ce <= 1'b0;
    tone_n <= n1;
    tone_r <= r1;
    tone_present <= 1'b1;
    repeat (40) @(posedge clk);
    check({7'h00, irq_oe}, 8'h00);
    tone_present <= 1'b0;
    @(posedge clk) ce <= 1'b1;
    hit(n1, r1, rep(2'h2, 5'h00));
    results;
  end
endmodule // tdc_top_tb
